//--- design/lpc_crc_engine.sv
// Serial CRC-8 packet-check engine with bit capture on the system clock at synchronised link-clock rising edges.
// Contract
// (R01) Each byte XORed into current check value.
// (R02) Shift left; XOR 0x07 when MSB set.
// (R03) Register remainder each step; eight steps/byte.
// (R04) Remainder kept to eight bits.
// (R05) Result becomes next check value, presented.
// (R06) Packet starts at zero or preload value.
// (R07) Host checks exactly the bytes it sends.
// (R08) Host verifies broadcast read check byte.
// (R09) Host may update check per byte.
// (R10) Write data LSB first, check follows; host model and deserialiser here shift MSB first.
// (R11) 40,09,FF,03 from zero gives 7F.
// (R12) Failed check sets readable error alert flag.
// (R13) Generator polynomial x^8+x^2+x+1.
// (R14) Only address, command, data bytes enter.
// (R15) Bits processed most significant first.
// (R16) Write executes only with valid check.
// (R17) Synchronous clear loads start value.
// (R18) Valid strobe accepted; done after eight steps.
`timescale 1ns/1ns
`default_nettype none
module lpc_crc_engine (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              link_clk,
  input  wire logic              link_data,
  input  wire logic              link_frame,
  input  wire logic              link_is_check,
  input  wire logic              pkt_clear,
  input  wire logic              preload_en,
  input  wire logic [7:0]        preload_value,
  input  wire logic              alert_clear,
  output logic [7:0]             running_check_value,
  output logic                   byte_done,
  output logic                   write_exec,
  output logic                   packet_check_error_alert,
  output logic                   busy,
  output logic                   rx_overflow
);
  import lpc_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} lpc_state_t;

  // Pins from the link pass two flip-flops before anything reads them.
  logic [1:0] clk_sync_ff;
  logic [1:0] dat_sync_ff;
  logic [1:0] frm_sync_ff;
  logic [1:0] chk_sync_ff;
  logic       clk_prev_ff;
  logic       rise;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      clk_sync_ff <= LPC_SYNC_ZERO;
      dat_sync_ff <= LPC_SYNC_ZERO;
      frm_sync_ff <= LPC_SYNC_ZERO;
      chk_sync_ff <= LPC_SYNC_ZERO;
      clk_prev_ff <= 1'b0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[0], link_clk};
      dat_sync_ff <= {dat_sync_ff[0], link_data};
      frm_sync_ff <= {frm_sync_ff[0], link_frame};
      chk_sync_ff <= {chk_sync_ff[0], link_is_check};
      clk_prev_ff <= clk_sync_ff[1];
    end
  end

  assign rise = clk_sync_ff[1] && !clk_prev_ff;

  // Deserialiser; start, stop and acknowledge bits are kept out by the framing signal.
  logic [7:0] sh_ff;
  logic [2:0] bit_cnt_ff;
  logic       in_valid_ff;
  lpc_byte_t  in_byte_ff;
  logic       in_ready;

  always_ff @(posedge clock) begin
    if (!nrst || pkt_clear) begin
      sh_ff       <= LPC_INIT_ZERO;
      bit_cnt_ff  <= LPC_STEP_ZERO;
      in_valid_ff <= 1'b0;
      in_byte_ff  <= '0;
    end else begin
      if (in_valid_ff && in_ready) begin
        in_valid_ff <= 1'b0;
      end
      if (rise && frm_sync_ff[1]) begin // R14
        sh_ff      <= {sh_ff[6:0], dat_sync_ff[1]}; // R15
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == LPC_LAST_STEP) begin
          in_byte_ff  <= '{is_check: chk_sync_ff[1], data: {sh_ff[6:0], dat_sync_ff[1]}};
          in_valid_ff <= 1'b1;
        end
      end
    end
  end

  // A byte arriving while the holding stage is full and the buffer is not ready sets the sticky overflow flag.
  always_ff @(posedge clock) begin
    if (!nrst || pkt_clear) begin
      rx_overflow <= 1'b0;
    end else if (rise && frm_sync_ff[1] && bit_cnt_ff == LPC_LAST_STEP
                 && in_valid_ff && !in_ready) begin
      rx_overflow <= 1'b1;
    end
  end

  lpc_byte_t q_byte;
  logic      q_valid;
  logic      q_ready;
  logic      buf_nrst;

  // Flushing the buffer at packet start keeps a stale byte out of the next packet.
  assign buf_nrst = nrst && !pkt_clear; // R17

  lpc_byte_buf u_buf (
    .clock     (clock),
    .nrst      (buf_nrst),
    .in_byte   (in_byte_ff),
    .in_valid  (in_valid_ff),
    .in_ready  (in_ready),
    .out_byte  (q_byte),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  // Engine: one shift per clock, so a byte costs eight shift cycles plus one to accept it.
  lpc_state_t  state_ff;
  logic [7:0]  rem_ff;
  logic [2:0]  step_ff;
  logic        cur_chk_ff;
  lpc_result_t res;

  assign q_ready = (state_ff == ST_IDLE) && !pkt_clear; // R18
  assign res     = '{mismatch: (lpc_step(rem_ff) != LPC_INIT_ZERO), value: lpc_step(rem_ff)};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff   <= ST_IDLE;
      rem_ff     <= LPC_INIT_ZERO;
      step_ff    <= LPC_STEP_ZERO;
      cur_chk_ff <= 1'b0;
    end else if (pkt_clear) begin
      // A new packet abandons a half-folded byte of the old one.
      state_ff <= ST_IDLE; // R17
      step_ff  <= LPC_STEP_ZERO;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (q_valid && q_ready) begin
            rem_ff     <= running_check_value ^ q_byte.data; // R01
            cur_chk_ff <= q_byte.is_check;
            step_ff    <= LPC_STEP_ZERO;
            state_ff   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          rem_ff  <= res.value; // R02 R03 R04 R13
          step_ff <= step_ff + 3'h1;
          if (step_ff == LPC_LAST_STEP) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  logic last_step;
  assign last_step = (state_ff == ST_SHIFT) && (step_ff == LPC_LAST_STEP) && !pkt_clear;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      running_check_value <= LPC_INIT_ZERO;
    end else if (pkt_clear) begin
      running_check_value <= preload_en ? preload_value : LPC_INIT_ZERO; // R06 R17
    end else if (last_step) begin
      running_check_value <= res.value; // R05 R11
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      byte_done  <= 1'b0;
      write_exec <= 1'b0;
      busy       <= 1'b0;
    end else begin
      byte_done  <= last_step; // R18
      // Folding the check byte in leaves zero exactly when it matched.
      write_exec <= last_step && cur_chk_ff && !res.mismatch; // R16
      busy       <= (state_ff == ST_SHIFT) && !last_step || (q_valid && q_ready);
    end
  end

  // Setting wins over a clear arriving in the same cycle.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      packet_check_error_alert <= 1'b0;
    end else if (last_step && cur_chk_ff && res.mismatch) begin
      packet_check_error_alert <= 1'b1; // R12
    end else if (alert_clear) begin
      packet_check_error_alert <= 1'b0;
    end
  end

  steps_per_byte_a: assert property (@(posedge clock) disable iff (!nrst || pkt_clear)
    (state_ff == ST_IDLE && q_valid && q_ready) |-> ##9 byte_done) // R03
    else $error("Byte did not finish after eight steps.");

  no_accept_busy_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == ST_SHIFT) |-> !q_ready) // R18
    else $error("Byte accepted while shifting.");

  poly_step_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == ST_SHIFT && rem_ff[7] && !pkt_clear)
    |=> (rem_ff == ({$past(rem_ff[6:0]), 1'b0} ^ LPC_POLY_LOW))) // R02
    else $error("Polynomial step wrong.");

  plain_step_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == ST_SHIFT && !rem_ff[7] && !pkt_clear)
    |=> (rem_ff == {$past(rem_ff[6:0]), 1'b0})) // R04
    else $error("Plain shift step wrong.");

  clear_start_a: assert property (@(posedge clock) disable iff (!nrst)
    (pkt_clear && !preload_en) |=> (running_check_value == 8'h00)) // R06
    else $error("Packet did not start at zero.");

  clear_preload_a: assert property (@(posedge clock) disable iff (!nrst)
    (pkt_clear && preload_en) |=> (running_check_value == $past(preload_value))) // R17
    else $error("Preload value not loaded.");

  error_alert_a: assert property (@(posedge clock) disable iff (!nrst)
    (last_step && cur_chk_ff && res.mismatch) |=> packet_check_error_alert) // R12
    else $error("Check error alert not set.");

  alert_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (packet_check_error_alert && !alert_clear) |=> packet_check_error_alert) // R12
    else $error("Check error alert not held.");

  exec_valid_a: assert property (@(posedge clock) disable iff (!nrst)
    write_exec |-> (byte_done && running_check_value == 8'h00)) // R16
    else $error("Write executed without a valid check.");

  hold_value_a: assert property (@(posedge clock) disable iff (!nrst)
    (!last_step && !pkt_clear) |=> $stable(running_check_value)) // R05
    else $error("Check value changed between bytes.");
endmodule : lpc_crc_engine
`default_nettype wire

//--- design/lpc_pkg.sv
// Package with types and constants for the ladder packet-check CRC engine.
package lpc_pkg;
  localparam int        LPC_W         = 8;
  localparam logic [7:0] LPC_POLY_LOW  = 8'h07;
  localparam logic [7:0] LPC_INIT_ZERO = 8'h00;
  localparam logic [2:0] LPC_LAST_STEP = 3'h7;
  localparam logic [2:0] LPC_STEP_ZERO = 3'h0;
  localparam logic [1:0] LPC_SYNC_ZERO = 2'h0;
  localparam logic [1:0] LPC_BUF_DEPTH = 2'h2;
  localparam logic [1:0] LPC_CNT_ZERO  = 2'h0;
  localparam logic [1:0] LPC_CNT_ONE   = 2'h1;
  localparam int        LPC_LINK_NS   = 160;
  localparam int        LPC_CLK_NS    = 10;
  localparam int        LPC_LINK_CYC  = LPC_LINK_NS / LPC_CLK_NS;

  // One byte entering the check, tagged as packet check byte or not.
  typedef struct packed {
    logic       is_check;
    logic [7:0] data;
  } lpc_byte_t;

  // Result of one shift step of the remainder; after the eighth step it is the byte folded into the running check value.
  typedef struct packed {
    logic       mismatch;
    logic [7:0] value;
  } lpc_result_t;

  function automatic logic [7:0] lpc_step(input logic [7:0] rem);
    lpc_step = rem[7] ? ({rem[6:0], 1'b0} ^ LPC_POLY_LOW) : {rem[6:0], 1'b0};
  endfunction : lpc_step
endpackage : lpc_pkg

//--- design/lpc_byte_buf.sv
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module lpc_byte_buf (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire lpc_pkg::lpc_byte_t in_byte,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output lpc_pkg::lpc_byte_t     out_byte,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  import lpc_pkg::*;

  lpc_byte_t  mem_ff [2];
  logic       wr_ptr_ff;
  logic       rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_ff != LPC_BUF_DEPTH);
  assign out_valid = (cnt_ff != LPC_CNT_ZERO);
  assign out_byte  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_byte;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= LPC_CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + LPC_CNT_ONE;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - LPC_CNT_ONE;
      end
    end
  end
endmodule : lpc_byte_buf
`default_nettype wire

//--- bench/lpc_host_model.sv
// Host-side model that shifts bytes onto the serial link.
`timescale 1ns/1ns
`default_nettype none
module lpc_host_model (
  input  wire logic clock,
  output logic      link_clk,
  output logic      link_data,
  output logic      link_frame,
  output logic      link_is_check
);
  import lpc_pkg::*;
  initial begin
    link_clk      = 1'b0;
    link_data     = 1'b0;
    link_frame    = 1'b0;
    link_is_check = 1'b0;
  end
  task automatic pulse();
    repeat (LPC_LINK_CYC / 2) @(posedge clock);
    link_clk <= 1'b1;
    repeat (LPC_LINK_CYC / 2) @(posedge clock);
    link_clk <= 1'b0;
  endtask : pulse
  // Each byte is sent MSB first and whole; the engine folds it once all eight bits have arrived.
  task automatic send_byte(input logic [7:0] b, input logic chk);
    for (int i = 7; i >= 0; i--) begin
      link_data     <= b[i];
      link_frame    <= 1'b1;
      link_is_check <= chk;
      pulse();
    end
    // The acknowledge slot is clocked but unframed, so it must stay out of the check.
    link_frame    <= 1'b0;
    link_is_check <= 1'b0;
    link_data     <= ~b[0];
    pulse();
  endtask : send_byte
endmodule : lpc_host_model
`default_nettype wire

//--- bench/lpc_crc_engine_tb.sv
// Self-checking bench for the packet-check CRC engine.
`timescale 1ns/1ns
`default_nettype none
module lpc_crc_engine_tb;
  import lpc_pkg::*;
  logic       clock, nrst, lclk, ldata, lframe, lchk;
  logic       pkt_clear, pre_en, alert_clear;
  logic [7:0] pre_val, chk_val, exp_value;
  logic       done, wexec, alert, busy, ovf, exec_exp, busy_seen;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cycles    = 0;
  lpc_crc_engine i_dut (.clock(clock), .nrst(nrst), .link_clk(lclk),
    .link_data(ldata), .link_frame(lframe), .link_is_check(lchk),
    .pkt_clear(pkt_clear), .preload_en(pre_en), .preload_value(pre_val),
    .alert_clear(alert_clear), .running_check_value(chk_val), .byte_done(done),
    .write_exec(wexec), .packet_check_error_alert(alert), .busy(busy),
    .rx_overflow(ovf));
  lpc_host_model i_host (.clock(clock), .link_clk(lclk), .link_data(ldata),
    .link_frame(lframe), .link_is_check(lchk));
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] ref_crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : ref_crc
  task automatic clear(input logic pre, input logic [7:0] v);
    @(posedge clock);
    pkt_clear <= 1'b1;
    pre_en    <= pre;
    pre_val   <= v;
    @(posedge clock);
    pkt_clear <= 1'b0;
    pre_en    <= 1'b0;
    exp_value = pre ? v : LPC_INIT_ZERO;
    repeat (2 * LPC_LINK_CYC) @(posedge clock);
    @(negedge clock);
    check(chk_val, exp_value);
    @(posedge clock);
  endtask : clear
  task automatic feed(input logic [7:0] b, input logic chk);
    exec_exp = chk && (ref_crc(exp_value, b) == 8'h00);
    exp_value = ref_crc(exp_value, b);
    busy_seen = 1'b0;
    fork
      i_host.send_byte(b, chk);
      begin
        for (int n = 0; n < 200 && done !== 1'b1; n++) begin
          @(negedge clock);
          busy_seen = busy_seen | busy;
        end
        check({7'h00, done}, 8'h01);
        check({7'h00, wexec}, {7'h00, exec_exp});
        check({6'h00, busy_seen, busy}, 8'h02);
      end
    join
    @(negedge clock);
    check(chk_val, exp_value);
    @(posedge clock);
  endtask : feed
  task automatic known_vector();
    clear(1'b0, 8'h00);
    feed(8'h40, 1'b0);
    feed(8'h09, 1'b0);
    feed(8'hFF, 1'b0);
    feed(8'h03, 1'b0);
    check(chk_val, 8'h7F);
    feed(8'h7F, 1'b1);
    check({7'h00, alert}, 8'h00);
  endtask : known_vector
  task automatic bad_check();
    clear(1'b0, 8'h00);
    feed(8'h40, 1'b0);
    feed(8'h09, 1'b0);
    feed(8'h7E, 1'b1);
    check({7'h00, alert}, 8'h01);
    @(posedge clock);
    alert_clear <= 1'b1;
    @(posedge clock);
    alert_clear <= 1'b0;
    @(negedge clock);
    check({7'h00, alert}, 8'h00);
  endtask : bad_check
  task automatic preload_start();
    clear(1'b1, ref_crc(ref_crc(8'h00, 8'h40), 8'h09));
    feed(8'hFF, 1'b0);
    feed(8'h03, 1'b0);
    check(chk_val, 8'h7F);
  endtask : preload_start
  // Bytes that set the top bit at some steps of the shift and clear it at others.
  task automatic msb_mix();
    logic [7:0] tbl [4];
    tbl = '{8'h80, 8'h01, 8'h00, 8'hFF};
    clear(1'b0, 8'h00);
    foreach (tbl[i])
      feed(tbl[i], 1'b0);
  endtask : msb_mix
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Fourteen bytes at about 150 cycles each fit well inside this ceiling.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  initial begin
    nrst        = 1'b0;
    pkt_clear   = 1'b0;
    pre_en      = 1'b0;
    pre_val     = 8'h00;
    alert_clear = 1'b0;
    exp_value   = 8'h00;
    exec_exp    = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check({alert, busy, done, wexec, ovf, 3'h0}, 8'h00);
    known_vector();
    bad_check();
    preload_start();
    msb_mix();
    check({7'h00, ovf}, 8'h00);
    give_verdict();
  end
endmodule : lpc_crc_engine_tb
`default_nettype wire
